// File: rtl/cspo_regs.sv
// core flags/page register, indirect pointer and hidden config word
// Notes on behaviour
// - flag-affecting write blocks z/dc/c write
// - timeout and powerdown ignore instruction writes
// - flags register is an ordinary destination
// - alu flag update overrides written bits
// - flags reset to 00011 plus flags
// - bit 5 selects program page
// - digit carry from nibble, inverted on subtract
// - pointer is an eight bit mapped register
// - low five pointer bits address memory
// - top pointer bits ignore writes
// - pointer bit 7 reads one after reset
// - config word write-only and unmapped
// - dedicated instruction loads accumulator into config
// - config drives power-fail, prescaler, timer
// - config word resets to 0x3f
// - indirect location redirects through pointer
// - self-referencing indirect read returns zero
// - program counter bit 8 from page bit
`timescale 1ns/100ps
`default_nettype none
module cspo_regs #(
   parameter bit LARGE_PROG = 1'b1   // program memory above 256 words
) (
   input  wire logic                   CLK_I,
   input  wire logic                   RST_I,
   // data memory access from the execution unit
   input  wire logic [4:0]             DM_ADDR_I,
   input  wire logic                   DM_RD_I,
   input  wire logic                   DM_WR_I,
   input  wire logic [7:0]             DM_WDATA_I,
   input  wire logic [7:0]             DM_RDATA_I,
   output logic      [4:0]             DM_ADDR_O,
   output logic                        DM_RE_O,
   output logic                        DM_WE_O,
   output logic      [7:0]             RD_DATA_O,
   // alu operands and flag enables
   input  wire cspo_pkg::cspo_alu_op_e ALU_OP_I,
   input  wire logic [7:0]             ALU_A_I,
   input  wire logic [7:0]             ALU_B_I,
   input  wire logic [2:0]             FLAG_WE_I,
   output logic      [7:0]             ALU_RESULT_O,
   // config word load
   input  wire logic [7:0]             ACC_I,
   input  wire logic                   CFG_LOAD_I,
   // watchdog and sleep events
   input  wire logic                   WATCHDOG_CLR_I,
   input  wire logic                   SLEEP_I,
   input  wire logic                   WATCHDOG_OVF_I,
   // state outputs
   output logic      [7:0]             FLAGS_PAGE_O,
   output logic      [7:0]             POINTER_O,
   output logic                        PC_BIT8_O,
   output logic      [7:0]             CFG_WORD_O,
   output logic                        CFG_LEVEL_O,
   output logic                        CFG_POWER_FAIL_EN_O,
   output logic                        CFG_TIMER_SRC_O,
   output logic                        CFG_TIMER_EDGE_O,
   output logic                        CFG_PRESCALE_WATCHDOG_O,
   output logic      [2:0]             CFG_PRESCALE_RATE_O
);
   // helper connections
   cspo_core_if cif ();

   // stored state
   logic [2:0] arith;          // zero, digit carry, carry
   logic       timeout_flag;   // watchdog time-out flag
   logic       powerdown_flag; // power-down flag
   logic       page_select_bit;// program page select
   logic [4:0] pointer;        // stored pointer bits
   logic [7:0] cfg_word;       // hidden config word
   logic [7:0] rd_data;        // registered read data

   // decoded access
   logic       wr_flags;       // write targets flags register
   logic       wr_pointer;     // write targets pointer
   logic       rd_flags;       // read targets flags register
   logic       rd_pointer;     // read targets pointer
   logic       ext_target;     // access leaves this block
   logic       flags_busy;     // instruction updates any alu flag
   logic [2:0] next_arith;     // next arithmetic flags
   logic [7:0] flags_view;     // readable flags register
   logic [7:0] pointer_view;   // readable pointer

   // alu helper wiring
   assign cif.op       = ALU_OP_I;
   assign cif.a        = ALU_A_I;
   assign cif.b        = ALU_B_I;
   assign cif.carry_in = arith[cspo_pkg::BIT_CARRY];
   assign cif.req_addr = DM_ADDR_I;
   assign cif.pointer  = pointer;

   // flag computation
   cspo_flag_calc u_flag (
      .f (cif.alu)
   );

   // address translation
   cspo_addr_xlat u_xlat (
      .x (cif.xlat)
   );

   // decode the effective target
   always_comb begin
      wr_flags   = 1'b0;
      wr_pointer = 1'b0;
      rd_flags   = 1'b0;
      rd_pointer = 1'b0;
      ext_target = 1'b0;
      // a self-referencing access touches nothing
      if (!cif.self_ref) begin
         case (cif.eff_addr)
            cspo_pkg::ADDR_FLAGS: begin
               wr_flags = DM_WR_I;
               rd_flags = DM_RD_I;
            end
            cspo_pkg::ADDR_POINTER: begin
               wr_pointer = DM_WR_I;
               rd_pointer = DM_RD_I;
            end
            default: begin
               ext_target = 1'b1;
            end
         endcase
      end
   end

   // memory side strobes, gated to outside locations
   assign DM_ADDR_O = cif.eff_addr;
   assign DM_RE_O   = DM_RD_I && ext_target;
   assign DM_WE_O   = DM_WR_I && ext_target;

   // any enabled flag update locks all three flag bits
   assign flags_busy = |FLAG_WE_I;

   // next arithmetic flags
   always_comb begin
      next_arith = arith;
      if (wr_flags && !flags_busy) begin
         next_arith = DM_WDATA_I[2:0];
      end
      if (FLAG_WE_I[cspo_pkg::BIT_ZERO]) begin
         next_arith[cspo_pkg::BIT_ZERO] = cif.zero;
      end
      if (FLAG_WE_I[cspo_pkg::BIT_DIGIT]) begin
         next_arith[cspo_pkg::BIT_DIGIT] = cif.digit;
      end
      if (FLAG_WE_I[cspo_pkg::BIT_CARRY]) begin
         next_arith[cspo_pkg::BIT_CARRY] = cif.carry;
      end
   end

   // arithmetic flags; reset value is really undefined, zero chosen
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         arith <= cspo_pkg::FLAGS_RST[2:0];
      end else begin
         arith <= next_arith;
      end
   end

   // page select, plain read/write bit
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         page_select_bit <= cspo_pkg::FLAGS_RST[cspo_pkg::BIT_PAGE];
      end else if (wr_flags) begin
         page_select_bit <= DM_WDATA_I[cspo_pkg::BIT_PAGE];
      end
   end

   // time-out flag; instruction writes never reach it
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         timeout_flag <= cspo_pkg::FLAGS_RST[cspo_pkg::BIT_TIMEOUT];
      end else if (WATCHDOG_CLR_I || SLEEP_I) begin
         timeout_flag <= 1'b1;
      end else if (WATCHDOG_OVF_I) begin
         timeout_flag <= 1'b0;
      end
   end

   // power-down flag; only internal events change it
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         powerdown_flag <= cspo_pkg::FLAGS_RST[cspo_pkg::BIT_POWERDOWN];
      end else if (WATCHDOG_CLR_I) begin
         powerdown_flag <= 1'b1;
      end else if (SLEEP_I) begin
         powerdown_flag <= 1'b0;
      end
   end

   // pointer keeps only its low bits
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         pointer <= cspo_pkg::POINTER_RST;
      end else if (wr_pointer) begin
         pointer <= DM_WDATA_I[4:0];
      end
   end

   // config word, reachable only by its own load strobe
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         cfg_word <= cspo_pkg::CFG_RST;
      end else if (CFG_LOAD_I) begin
         cfg_word <= ACC_I;
      end
   end

   // readable views; flags bits 7 and 6 read zero, pointer bits 7 to 5 read one
   assign flags_view = {2'b00, page_select_bit, timeout_flag,
                        powerdown_flag, arith};
   assign pointer_view = {cspo_pkg::POINTER_TOP, pointer};

   // read data registered one edge after the read strobe
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         rd_data <= 8'h00;
      end else if (DM_RD_I) begin
         if (cif.self_ref) begin
            rd_data <= 8'h00;
         end else if (rd_flags) begin
            rd_data <= flags_view;
         end else if (rd_pointer) begin
            rd_data <= pointer_view;
         end else begin
            rd_data <= DM_RDATA_I;
         end
      end
   end
   assign RD_DATA_O = rd_data;

   // alu result straight from the helper for write-back
   assign ALU_RESULT_O = cif.result;

   // state outputs
   assign FLAGS_PAGE_O = flags_view;
   assign POINTER_O    = pointer_view;
   // page bit feeds pc bit 8
   assign PC_BIT8_O    = LARGE_PROG & page_select_bit;

   assign CFG_WORD_O              = cfg_word;
   assign CFG_LEVEL_O             = cfg_word[cspo_pkg::CFG_LEVEL];
   assign CFG_POWER_FAIL_EN_O     = cfg_word[cspo_pkg::CFG_PF_EN];
   assign CFG_TIMER_SRC_O         = cfg_word[cspo_pkg::CFG_SRC];
   assign CFG_TIMER_EDGE_O        = cfg_word[cspo_pkg::CFG_EDGE];
   assign CFG_PRESCALE_WATCHDOG_O = cfg_word[cspo_pkg::CFG_ASSIGN];
   assign CFG_PRESCALE_RATE_O     = cfg_word[cspo_pkg::CFG_RATE_MSB:0];
endmodule : cspo_regs
`default_nettype wire

// File: rtl/cspo_pkg.sv
// constants and types shared by the core status/pointer/config register block
package cspo_pkg;
   // data memory map locations handled here
   localparam logic [4:0] ADDR_INDIRECT = 5'h00;
   localparam logic [4:0] ADDR_FLAGS    = 5'h03;
   localparam logic [4:0] ADDR_POINTER  = 5'h04;
   // flags register field positions
   localparam int BIT_CARRY     = 0;
   localparam int BIT_DIGIT     = 1;
   localparam int BIT_ZERO      = 2;
   localparam int BIT_POWERDOWN = 3;
   localparam int BIT_TIMEOUT   = 4;
   localparam int BIT_PAGE      = 5;
   // reset values
   localparam logic [7:0] FLAGS_RST   = 8'h18;
   localparam logic [4:0] POINTER_RST = 5'h00;
   localparam logic [2:0] POINTER_TOP = 3'h7;
   localparam logic [7:0] CFG_RST     = 8'h3f;
   // config word field positions
   localparam int CFG_LEVEL    = 7;
   localparam int CFG_PF_EN    = 6;
   localparam int CFG_SRC      = 5;
   localparam int CFG_EDGE     = 4;
   localparam int CFG_ASSIGN   = 3;
   localparam int CFG_RATE_MSB = 2;
   // alu operation classes that shape the flags
   typedef enum logic [2:0] {
      ALU_PASS,
      ALU_ADD,
      ALU_SUB,
      ALU_ROT_L,
      ALU_ROT_R
   } cspo_alu_op_e;
endpackage : cspo_pkg

// File: rtl/cspo_core_if.sv
// interface joining the register core to its flag and address helpers
`timescale 1ns/100ps
`default_nettype none
interface cspo_core_if;
   cspo_pkg::cspo_alu_op_e op;  // operation class
   logic [7:0] a;               // first operand
   logic [7:0] b;               // second operand
   logic       carry_in;        // stored carry for rotates
   logic [7:0] result;          // alu result
   logic       zero;            // computed zero flag
   logic       digit;           // computed digit carry flag
   logic       carry;           // computed carry flag
   logic [4:0] req_addr;        // address named by the instruction
   logic [4:0] pointer;         // stored pointer bits
   logic [4:0] eff_addr;        // address after redirection
   logic       self_ref;        // pointer selects the indirect location
   modport alu  (input op, a, b, carry_in, output result, zero, digit, carry);
   modport xlat (input req_addr, pointer, output eff_addr, self_ref);
   modport core (output op, a, b, carry_in, req_addr, pointer,
                 input result, zero, digit, carry, eff_addr, self_ref);
endinterface : cspo_core_if
`default_nettype wire

// File: rtl/cspo_flag_calc.sv
// flag computation for the alu result
`timescale 1ns/100ps
`default_nettype none
module cspo_flag_calc (
   cspo_core_if.alu f
);
   logic [8:0] sum9;   // widened add or subtract
   logic [4:0] low5;   // widened low nibble
   // arithmetic and flags, purely combinational
   always_comb begin
      sum9     = 9'h000;
      low5     = 5'h00;
      f.result = f.a;
      f.digit  = 1'b0;
      f.carry  = f.carry_in;
      case (f.op)
         cspo_pkg::ALU_ADD: begin
            sum9     = {1'b0, f.a} + {1'b0, f.b};
            low5     = {1'b0, f.a[3:0]} + {1'b0, f.b[3:0]};
            f.result = sum9[7:0];
            f.digit  = low5[4];
            f.carry  = sum9[8];
         end
         cspo_pkg::ALU_SUB: begin
            sum9     = {1'b0, f.a} - {1'b0, f.b};
            low5     = {1'b0, f.a[3:0]} - {1'b0, f.b[3:0]};
            f.result = sum9[7:0];
            f.digit  = ~low5[4];
            f.carry  = ~sum9[8];
         end
         cspo_pkg::ALU_ROT_L: begin
            f.result = {f.a[6:0], f.carry_in};
            f.carry  = f.a[7];
         end
         cspo_pkg::ALU_ROT_R: begin
            f.result = {f.carry_in, f.a[7:1]};
            f.carry  = f.a[0];
         end
         // logic results arrive already formed
         default: begin
            f.result = f.a;
         end
      endcase
   end
   assign f.zero = (f.result == 8'h00);
endmodule : cspo_flag_calc
`default_nettype wire

// File: rtl/cspo_addr_xlat.sv
// data memory address translation for indirect access
`timescale 1ns/100ps
`default_nettype none
module cspo_addr_xlat (
   cspo_core_if.xlat x
);
   logic indirect;   // instruction names the indirect location
   // detect the indirect location
   assign indirect = (x.req_addr == cspo_pkg::ADDR_INDIRECT);
   assign x.eff_addr = indirect ? x.pointer : x.req_addr;
   assign x.self_ref = indirect && (x.pointer == cspo_pkg::ADDR_INDIRECT);
endmodule : cspo_addr_xlat
`default_nettype wire

// File: test/cspo_regs_props.sv
// assertion checker for the status/pointer/config register block
`timescale 1ns/100ps
`default_nettype none
module cspo_regs_props (
   input wire logic       CLK_I,
   input wire logic       RST_I,
   input wire logic [4:0] DM_ADDR_I,
   input wire logic       DM_WR_I,
   input wire logic [7:0] DM_WDATA_I,
   input wire logic [4:0] DM_ADDR_O,
   input wire logic       DM_WE_O,
   input wire logic [2:0] FLAG_WE_I,
   input wire logic [7:0] ACC_I,
   input wire logic       CFG_LOAD_I,
   input wire logic       WATCHDOG_CLR_I,
   input wire logic       SLEEP_I,
   input wire logic       WATCHDOG_OVF_I,
   input wire logic [7:0] FLAGS_PAGE_O,
   input wire logic [7:0] POINTER_O,
   input wire logic       PC_BIT8_O,
   input wire logic [7:0] CFG_WORD_O
);
   default clocking cb @(posedge CLK_I); endclocking
   logic st_wr; // write aimed at the flags register
   logic no_ev; // no watchdog or sleep event this cycle
   assign st_wr = DM_WR_I && (DM_ADDR_I == 5'h03);
   assign no_ev = !SLEEP_I && !WATCHDOG_CLR_I && !WATCHDOG_OVF_I;
   a_reset_load: assert property (RST_I |=> FLAGS_PAGE_O == 8'h18 && CFG_WORD_O == 8'h3f)
      else $error("reset values wrong");
   a_ptr_top: assert property (disable iff (RST_I) POINTER_O[7:5] == 3'h7)
      else $error("pointer top bits wrong");
   a_cfg_load: assert property (disable iff (RST_I) CFG_LOAD_I |=> CFG_WORD_O == $past(ACC_I))
      else $error("config load wrong");
   a_cfg_keep: assert property (disable iff (RST_I) !CFG_LOAD_I |=> $stable(CFG_WORD_O))
      else $error("config changed without load");
   a_status_rsvd: assert property (disable iff (RST_I) st_wr && no_ev |=>
      FLAGS_PAGE_O[7:3] == {2'b00, $past(DM_WDATA_I[5]), $past(FLAGS_PAGE_O[4:3])})
      else $error("status upper bits wrong");
   a_status_write: assert property (disable iff (RST_I) st_wr && FLAG_WE_I == 3'h0 |=>
      FLAGS_PAGE_O[2:0] == $past(DM_WDATA_I[2:0]))
      else $error("status write lost");
   a_flag_block: assert property (disable iff (RST_I) st_wr && FLAG_WE_I != 3'h0 |=>
      ((FLAGS_PAGE_O[2:0] ^ $past(FLAGS_PAGE_O[2:0])) & ~$past(FLAG_WE_I)) == 3'h0)
      else $error("blocked flag bit written");
   a_indirect_map: assert property (disable iff (RST_I)
      DM_ADDR_I == 5'h00 |-> DM_ADDR_O == POINTER_O[4:0])
      else $error("indirect address wrong");
   a_no_ext_wr: assert property (disable iff (RST_I) DM_WR_I && (DM_ADDR_I == 5'h03 ||
      DM_ADDR_I == 5'h04 || DM_ADDR_O == 5'h00) |-> !DM_WE_O)
      else $error("external write leaked");
   a_sleep_pd: assert property (disable iff (RST_I) SLEEP_I && !WATCHDOG_CLR_I |=>
      !FLAGS_PAGE_O[3] && FLAGS_PAGE_O[4])
      else $error("sleep flags wrong");
   a_page_pc: assert property (disable iff (RST_I) PC_BIT8_O == FLAGS_PAGE_O[5])
      else $error("program page bit wrong");
endmodule : cspo_regs_props
bind cspo_regs cspo_regs_props i_cspo_regs_props (.CLK_I(CLK_I), .RST_I(RST_I),
   .DM_ADDR_I(DM_ADDR_I), .DM_WR_I(DM_WR_I), .DM_WDATA_I(DM_WDATA_I),
   .DM_ADDR_O(DM_ADDR_O), .DM_WE_O(DM_WE_O), .FLAG_WE_I(FLAG_WE_I), .ACC_I(ACC_I),
   .CFG_LOAD_I(CFG_LOAD_I), .WATCHDOG_CLR_I(WATCHDOG_CLR_I), .SLEEP_I(SLEEP_I),
   .WATCHDOG_OVF_I(WATCHDOG_OVF_I), .FLAGS_PAGE_O(FLAGS_PAGE_O), .POINTER_O(POINTER_O),
   .PC_BIT8_O(PC_BIT8_O), .CFG_WORD_O(CFG_WORD_O));
`default_nettype wire

// File: test/cspo_ram_model.sv
// data memory model standing behind the effective address bus
`timescale 1ns/100ps
`default_nettype none
module cspo_ram_model (
   input  wire logic       clk_i,
   input  wire logic [4:0] addr_i,
   input  wire logic       re_i,
   input  wire logic       we_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] rdata_o
);
   logic [7:0] mem [32];     // ram cells
   logic [7:0] last = 8'h00; // last value put on the bus
   // store on the edge that takes the strobe
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
      if (re_i) begin
         last <= mem[addr_i];
      end
   end
   // unselected bus shows the inverse, so a stale value never matches by luck
   assign rdata_o = re_i ? mem[addr_i] : ~last;
endmodule : cspo_ram_model
`default_nettype wire

// File: test/tb_cspo_regs.sv
// self-checking bench for the status/pointer/config register block
`timescale 1ns/100ps
`default_nettype none
module tb_cspo_regs;
   logic                   clk, rst, rd, wr, cfg_ld, re_o, we_o, pc8;
   logic                   lvl, pfe, src, edg, psw;
   logic [2:0]             flag_we, rate, ev; // ev is {clear, sleep, overflow}
   logic [4:0]             addr, addr_o;
   logic [7:0]             wdata, rdata, rd_data, alu_a, alu_b, alu_res, acc, flags, ptr, cfg;
   cspo_pkg::cspo_alu_op_e op;
   int                     fail_count = 0;
   int                     checks = 0;
   // alu cases: operation, operands, enables, result, {z,dc,c}
   cspo_pkg::cspo_alu_op_e ops [7] = '{cspo_pkg::ALU_ADD, cspo_pkg::ALU_SUB, cspo_pkg::ALU_SUB,
      cspo_pkg::ALU_ADD, cspo_pkg::ALU_ROT_L, cspo_pkg::ALU_ROT_R, cspo_pkg::ALU_PASS};
   logic [7:0] ta [7] = '{8'h0f, 8'h05, 8'h00, 8'hff, 8'h80, 8'h02, 8'h00};
   logic [7:0] tb [7] = '{8'h01, 8'h05, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
   logic [2:0] tw [7] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h5, 3'h5, 3'h4};
   logic [7:0] tr [7] = '{8'h10, 8'h00, 8'hff, 8'h00, 8'h01, 8'h81, 8'h00};
   logic [2:0] tf [7] = '{3'h2, 3'h7, 3'h0, 3'h7, 3'h3, 3'h2, 3'h6};
   cspo_regs i_cspo_regs (.CLK_I(clk), .RST_I(rst), .DM_ADDR_I(addr), .DM_RD_I(rd),
      .DM_WR_I(wr), .DM_WDATA_I(wdata), .DM_RDATA_I(rdata), .DM_ADDR_O(addr_o),
      .DM_RE_O(re_o), .DM_WE_O(we_o), .RD_DATA_O(rd_data), .ALU_OP_I(op), .ALU_A_I(alu_a),
      .ALU_B_I(alu_b), .FLAG_WE_I(flag_we), .ALU_RESULT_O(alu_res), .ACC_I(acc),
      .CFG_LOAD_I(cfg_ld), .WATCHDOG_CLR_I(ev[2]), .SLEEP_I(ev[1]), .WATCHDOG_OVF_I(ev[0]),
      .FLAGS_PAGE_O(flags), .POINTER_O(ptr), .PC_BIT8_O(pc8), .CFG_WORD_O(cfg),
      .CFG_LEVEL_O(lvl), .CFG_POWER_FAIL_EN_O(pfe), .CFG_TIMER_SRC_O(src),
      .CFG_TIMER_EDGE_O(edg), .CFG_PRESCALE_WATCHDOG_O(psw), .CFG_PRESCALE_RATE_O(rate));
   cspo_ram_model i_cspo_ram_model (.clk_i(clk), .addr_i(addr_o), .re_i(re_o), .we_i(we_o),
      .wdata_i(wdata), .rdata_o(rdata));
   // free-running core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // reset held two cycles, then the documented start values
   task automatic do_reset();
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("flags", flags, 8'h18);
      chk("pointer top", ptr & 8'he0, 8'he0);
      chk("config", cfg, 8'h3f);
   endtask : do_reset
   // strobes last one cycle, launched off the falling edge
   task automatic wr_dm(input logic [4:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_dm
   task automatic rd_dm(input logic [4:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk("read data", rd_data, exp);
   endtask : rd_dm
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      {rst, rd, wr, cfg_ld, flag_we, ev, addr, wdata, alu_a, alu_b, acc} = '0;
      op = cspo_pkg::ALU_PASS;
      do_reset();
      $display("reset test done");
      // software writes status with flag-neutral moves
      wr_dm(5'h03, 8'hff);
      chk("flags", flags, 8'h3f);
      chk("pc bit8", {7'h00, pc8}, 8'h01);
      rd_dm(5'h03, 8'h3f);
      wr_dm(5'h03, 8'h00);
      chk("flags", flags, 8'h18);
      wr_dm(5'h04, 8'h05);
      chk("pointer", ptr, 8'he5);
      wr_dm(5'h00, 8'ha5);
      rd_dm(5'h05, 8'ha5);
      wr_dm(5'h05, 8'h3c);
      rd_dm(5'h00, 8'h3c);
      wr_dm(5'h04, 8'h00);
      rd_dm(5'h04, 8'he0);
      wr_dm(5'h00, 8'h77);
      rd_dm(5'h00, 8'h00);
      $display("memory map test done");
      for (int i = 0; i < 7; i++) begin
         op = ops[i];
         alu_a = ta[i];
         alu_b = tb[i];
         flag_we = tw[i];
         #1 chk("alu result", alu_res, tr[i]);
         @(negedge clk);
         flag_we = 3'h0;
         chk("alu flags", {5'h00, flags[2:0]}, {5'h00, tf[i]});
      end
      // flag-setting instruction aimed at the status register
      op = cspo_pkg::ALU_ADD;
      alu_a = 8'hff;
      alu_b = 8'h01;
      flag_we = 3'h7;
      wr_dm(5'h03, 8'h20);
      chk("flags", flags, 8'h3f);
      op = cspo_pkg::ALU_PASS;
      alu_a = 8'h05;
      flag_we = 3'h4;
      wr_dm(5'h03, 8'h00);
      flag_we = 3'h0;
      chk("flags", flags, 8'h1b);
      $display("flag test done");
      for (int i = 0; i < 3; i++) begin
         ev = (i == 2) ? 3'h4 : (3'h2 >> i);
         @(negedge clk);
         ev = 3'h0;
         chk("wake flags", {6'h00, flags[4:3]}, (i == 0) ? 8'h02 : (i == 1) ? 8'h00 : 8'h03);
      end
      acc = 8'hc5;
      cfg_ld = 1'b1;
      @(negedge clk);
      cfg_ld = 1'b0;
      acc = 8'h00;
      chk("config", cfg, 8'hc5);
      chk("config fields", {lvl, pfe, src, edg, psw, rate}, 8'hc5);
      wr_dm(5'h03, 8'h00);
      chk("config", cfg, 8'hc5);
      $display("event and config test done");
      do_reset();
      end_of_test();
   end
   // hang guard
   initial begin
      #100000;
      fail_count++;
      end_of_test();
   end
endmodule : tb_cspo_regs
`default_nettype wire
